// *** verilog/pfc_map.svh ***
// Purpose: Address map, field positions, codes and counts of the printer format control block.
// Assumes: 32-bit APB data, 12-bit byte address.
// Notes: Definitions only.
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

`define PFC_TRACK_LEN   100
`define PFC_NUM_POS     80
`define PFC_NUM_ANA     4
`define PFC_CHAR_W      6
`define PFC_ROUTE_W     7
`define PFC_ROUTE_SPACE 7'h64
`define PFC_ROUTE_NONE  7'h7f
`define PFC_LAST_POS    7'h4f
`define PFC_CHAR_BLANK  6'h00
`define PFC_DIGIT_ZERO  4'ha
`define PFC_ZONE_12     2'h1
`define PFC_ZONE_11     2'h2
`define PFC_ZONE_0      2'h3

`define PFC_OFS_CTRL    12'h000
`define PFC_OFS_CMD     12'h004
`define PFC_OFS_STATUS  12'h008
`define PFC_OFS_CHKRST  12'h00c
`define PFC_ANA_BASE    12'h010
`define PFC_ANA_MASK    12'hff0
`define PFC_ROUTE_BASE  12'h200
`define PFC_TRACK_BASE  12'h400
`define PFC_BLK_MASK    12'he00

`define PFC_CTRL_INTERLOCK 0
`define PFC_CTRL_PRINTON   1
`define PFC_CMD_PRINT      0
`define PFC_CHKRST_BIT     0
`define PFC_ST_BUSY        0
`define PFC_ST_SETUPERR    1
`define PFC_ST_CHECK       2
`define PFC_ST_PRINTON     3
`define PFC_ST_POS_LSB     8

`endif

// *** verilog/pfc_pkg.sv ***
// Purpose: Types shared by the printer format control block.
// Assumes: pfc_map.svh gives the track, routing and character widths.
// Notes: Whole module state lives in pfc_state_t.
`include "pfc_map.svh"
package pfc_pkg;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ANA   = 4'b0010,
		ST_PRINT = 4'b0100,
		ST_END   = 4'b1000
	} pfc_fsm_t;

	typedef struct packed {
		pfc_fsm_t                                              fsm;
		logic [`PFC_TRACK_LEN-1:0][`PFC_CHAR_W-1:0]            track;
		logic [`PFC_NUM_POS-1:0][`PFC_ROUTE_W-1:0]             route;
		logic [`PFC_NUM_ANA-1:0][`PFC_ROUTE_W-1:0]             trigRoute;
		logic                                                  interlock;
		logic                                                  printOnInit;
		logic [1:0]                                            anaIdx;
		logic [`PFC_ROUTE_W-1:0]                               pos;
		logic [15:0]                                           divCnt;
		logic                                                  printOn;
		logic                                                  setupErr;
		logic                                                  checkInd;
		logic [9:0]                                            heldDigit;
		logic [2:0]                                            heldZone;
		logic                                                  heldBlank;
		logic [1:0][9:0]                                       resDigit;
		logic [1:0][2:0]                                       resZone;
		logic [1:0]                                            resBlank;
		logic                                                  earlyPulse;
		logic                                                  latePulse;
		logic                                                  posStrobe;
		logic [`PFC_ROUTE_W-1:0]                               posIdx;
		logic                                                  charStrobe;
		logic [`PFC_CHAR_W-1:0]                                charCode;
		logic                                                  spaceStrobe;
		logic                                                  lineDone;
		logic                                                  pready;
		logic                                                  pslverr;
		logic [31:0]                                           prdata;
	} pfc_state_t;

endpackage : pfc_pkg

// *** verilog/pfc_analyzer.sv ***
// Purpose: Decodes one track character into digit, zone and blank indications.
// Assumes: Character is {zone[1:0], digit[3:0]}, digit 1..9 or zero code, 0 means no punch.
// Notes: Purely combinational; caller registers and times the outputs.
`timescale 1ns/1ns
`include "pfc_map.svh"
module pfc_analyzer (
	input  wire logic [`PFC_CHAR_W-1:0] charCode,
	input  wire logic                   connected,
	output logic      [9:0]             digitHit,
	output logic      [2:0]             zoneHit,
	output logic                        blankInd
);

	logic [3:0] digit;
	logic [1:0] zone;

	assign digit = charCode[3:0];
	assign zone  = charCode[5:4];

	// One digit line per punch, zero punch lands on line 0
	always_comb begin
		digitHit = 10'h000;
		zoneHit  = 3'h0;
		if (connected) begin
			for (int d = 1; d < 10; d++) begin
				if (digit == 4'(d)) digitHit[d] = 1'b1;
			end
			if (digit == `PFC_DIGIT_ZERO) digitHit[0] = 1'b1;
			zoneHit[0] = (zone == `PFC_ZONE_12);
			zoneHit[1] = (zone == `PFC_ZONE_11);
			zoneHit[2] = (zone == `PFC_ZONE_0);
		end
	end

	// Unconnected trigger reads as blank; caller applies multi-line suppression
	assign blankInd = !connected || (charCode == `PFC_CHAR_BLANK);

endmodule : pfc_analyzer

// *** verilog/pfc_format_control.sv ***
// Purpose: Format control of a serial line printer: analysis phase, then 80-position print walk.
// Assumes: Single 100 MHz clock, APB register access, control pulses synchronous and one cycle wide.
// Notes: Track buffer, routing table and trigger routes are written by software over APB.
//
// How it works
// - Hold 100-character track; each position may pick any one character.
// - No print starts unless the interlock bit is closed by software.
// - One position strobe per print position, 80 in a full line.
// - Position routed to track index prints that track character there.
// - Position routed to nothing while printing raises a setup error.
// - Position routed to space is skipped silently, no error.
// - Space routing is demanded only while the print-on state is set.
// - Print command with track loaded runs analysis before the head moves.
// - Analyzer pulses the digit line matching the analysed digit.
// - Letters pulse both zone line and digit line of their card code.
// - Blank line pulses unless the analysed position holds a character.
// - Unconnected trigger gives blank except on multi-line cycles 2 to 4.
// - Triggers A, B, C, D fire and set up in that order.
// - Results of A and B leave together right after B sets up.
// - Results of C and D leave together right after D sets up.
// - Routing paths carry position strobes to the track unchanged.
// - Printing ends on line-end pulse or after all 80 positions.
// - Print stop suppresses printing and setup checks until print start.
// - Check indicator sets on parity error or setup error.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "pfc_map.svh"
module pfc_format_control #(
	parameter int STEP_DIV = 4
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   printStart,
	input  wire logic                   printStop,
	input  wire logic                   lineEnd,
	input  wire logic                   parityErr,
	input  wire logic                   checkReset,
	input  wire logic [1:0]             multiLineStep,
	output logic                        busy,
	output logic                        posStrobe,
	output logic      [`PFC_ROUTE_W-1:0] posIdx,
	output logic                        charStrobe,
	output logic      [`PFC_CHAR_W-1:0] charCode,
	output logic                        spaceStrobe,
	output logic                        lineDone,
	output logic                        setupErr,
	output logic                        checkInd,
	output logic                        earlyPulse,
	output logic                        latePulse,
	output logic      [9:0]             resDigit0,
	output logic      [9:0]             resDigit1,
	output logic      [2:0]             resZone0,
	output logic      [2:0]             resZone1,
	output logic                        resBlank0,
	output logic                        resBlank1
);

	// Divider counter is 16 bits wide
	initial begin
		if (STEP_DIV < 1 || STEP_DIV > 65535) begin
			$error("STEP_DIV out of range");
		end
	end

	localparam logic [15:0] STEP_LAST = 16'(STEP_DIV - 1);

	pfc_pkg::pfc_state_t st_r;
	pfc_pkg::pfc_state_t st_nxt;

	logic                    anaConn;
	logic [`PFC_CHAR_W-1:0]  anaChar;
	logic [9:0]              anaDigit;
	logic [2:0]              anaZone;
	logic                    anaBlank;
	logic [`PFC_ROUTE_W-1:0] anaRoute;

	// Address decode, shared by read path and write path
	function automatic logic addrMapped(input logic [11:0] a);
		logic [6:0] idx;
		idx = a[8:2];
		if (a[1:0] != 2'h0) return 1'b0;
		if (a == `PFC_OFS_CTRL || a == `PFC_OFS_CMD) return 1'b1;
		if (a == `PFC_OFS_STATUS || a == `PFC_OFS_CHKRST) return 1'b1;
		if ((a & `PFC_ANA_MASK) == `PFC_ANA_BASE) return 1'b1;
		if ((a & `PFC_BLK_MASK) == `PFC_ROUTE_BASE) return idx < 7'(`PFC_NUM_POS);
		if ((a & `PFC_BLK_MASK) == `PFC_TRACK_BASE) return idx < 7'(`PFC_TRACK_LEN);
		return 1'b0;
	endfunction : addrMapped

	// Analyzer triggers fire one per cycle, A first
	assign anaRoute = st_r.trigRoute[st_r.anaIdx];
	assign anaConn  = anaRoute < 7'(`PFC_TRACK_LEN);
	assign anaChar  = anaConn ? st_r.track[anaRoute] : `PFC_CHAR_BLANK;

	pfc_analyzer u_analyzer (
		.charCode  (anaChar),
		.connected (anaConn),
		.digitHit  (anaDigit),
		.zoneHit   (anaZone),
		.blankInd  (anaBlank)
	);

	// Next-state logic for bus, analysis and print walk
	always_comb begin
		logic       wrEn;
		logic       rdPhase;
		logic [6:0] idx;
		logic       stepEn;
		logic       onNow;
		logic       blankNow;
		logic [6:0] r;
		wrEn     = 1'b0;
		rdPhase  = 1'b0;
		idx      = 7'h00;
		stepEn   = 1'b0;
		onNow    = 1'b0;
		blankNow = 1'b0;
		r        = `PFC_ROUTE_NONE;
		st_nxt   = st_r;

		// Pulses last one cycle
		st_nxt.earlyPulse  = 1'b0;
		st_nxt.latePulse   = 1'b0;
		st_nxt.resDigit    = '0;
		st_nxt.resZone     = '0;
		st_nxt.resBlank    = '0;
		st_nxt.posStrobe   = 1'b0;
		st_nxt.charStrobe  = 1'b0;
		st_nxt.spaceStrobe = 1'b0;
		st_nxt.lineDone    = 1'b0;

		// APB: answer prepared in setup, taken at the access edge
		rdPhase           = psel && !penable;
		wrEn              = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
		idx               = paddr[8:2];
		st_nxt.pready     = rdPhase;
		st_nxt.pslverr    = rdPhase && !addrMapped(paddr);
		if (rdPhase) begin
			st_nxt.prdata = 32'h0000_0000;
			if (paddr == `PFC_OFS_CTRL) begin
				st_nxt.prdata[`PFC_CTRL_INTERLOCK] = st_r.interlock;
				st_nxt.prdata[`PFC_CTRL_PRINTON]   = st_r.printOnInit;
			end else if (paddr == `PFC_OFS_STATUS) begin
				st_nxt.prdata[`PFC_ST_BUSY]     = !(st_r.fsm == pfc_pkg::ST_IDLE);
				st_nxt.prdata[`PFC_ST_SETUPERR] = st_r.setupErr;
				st_nxt.prdata[`PFC_ST_CHECK]    = st_r.checkInd;
				st_nxt.prdata[`PFC_ST_PRINTON]  = st_r.printOn;
				st_nxt.prdata[`PFC_ST_POS_LSB +: `PFC_ROUTE_W] = st_r.pos;
			end else if ((paddr & `PFC_ANA_MASK) == `PFC_ANA_BASE) begin
				st_nxt.prdata[`PFC_ROUTE_W-1:0] = st_r.trigRoute[paddr[3:2]];
			end else if ((paddr & `PFC_BLK_MASK) == `PFC_ROUTE_BASE && addrMapped(paddr)) begin
				st_nxt.prdata[`PFC_ROUTE_W-1:0] = st_r.route[idx];
			end else if ((paddr & `PFC_BLK_MASK) == `PFC_TRACK_BASE && addrMapped(paddr)) begin
				st_nxt.prdata[`PFC_CHAR_W-1:0] = st_r.track[idx];
			end
		end
		if (wrEn) begin
			if (paddr == `PFC_OFS_CTRL) begin
				st_nxt.interlock   = pwdata[`PFC_CTRL_INTERLOCK];
				st_nxt.printOnInit = pwdata[`PFC_CTRL_PRINTON];
			end else if ((paddr & `PFC_ANA_MASK) == `PFC_ANA_BASE) begin
				st_nxt.trigRoute[paddr[3:2]] = pwdata[`PFC_ROUTE_W-1:0];
			end else if ((paddr & `PFC_BLK_MASK) == `PFC_ROUTE_BASE) begin
				st_nxt.route[idx] = pwdata[`PFC_ROUTE_W-1:0];
			end else if ((paddr & `PFC_BLK_MASK) == `PFC_TRACK_BASE) begin
				st_nxt.track[idx] = pwdata[`PFC_CHAR_W-1:0];
			end
		end

		// Clears first so a same-cycle set below wins
		if (checkReset || (wrEn && paddr == `PFC_OFS_CHKRST && pwdata[`PFC_CHKRST_BIT])) begin
			st_nxt.setupErr = 1'b0;
			st_nxt.checkInd = 1'b0;
		end
		if (parityErr) begin
			st_nxt.checkInd = 1'b1;
		end

		// Print-on state follows start and stop pulses; start wins a tie
		onNow = printStart ? 1'b1 : (printStop ? 1'b0 : st_r.printOn);

		unique case (st_r.fsm)
			pfc_pkg::ST_IDLE: begin
				// Sticky errors and an open interlock both refuse the command
				if (wrEn && paddr == `PFC_OFS_CMD && pwdata[`PFC_CMD_PRINT] && st_r.interlock
						&& !st_r.setupErr && !st_r.checkInd) begin
					st_nxt.fsm    = pfc_pkg::ST_ANA;
					st_nxt.anaIdx = 2'h0;
					st_nxt.pos    = 7'h00;
				end
			end
			pfc_pkg::ST_ANA: begin
				// Blank is held back on later multi-line cycles if unconnected
				blankNow = anaBlank && !(!anaConn && multiLineStep != 2'h0);
				st_nxt.anaIdx = st_r.anaIdx + 2'h1;
				if (!st_r.anaIdx[0]) begin
					st_nxt.heldDigit = anaDigit;
					st_nxt.heldZone  = anaZone;
					st_nxt.heldBlank = blankNow;
				end else begin
					// A/B then C/D leave as a pair right after the second sets up
					st_nxt.resDigit[0] = st_r.heldDigit;
					st_nxt.resZone[0]  = st_r.heldZone;
					st_nxt.resBlank[0] = st_r.heldBlank;
					st_nxt.resDigit[1] = anaDigit;
					st_nxt.resZone[1]  = anaZone;
					st_nxt.resBlank[1] = blankNow;
					if (st_r.anaIdx[1]) begin
						st_nxt.latePulse = 1'b1;
						st_nxt.fsm       = pfc_pkg::ST_PRINT;
						st_nxt.divCnt    = 16'h0000;
						st_nxt.printOn   = st_r.printOnInit;
						onNow            = st_r.printOnInit;
					end else begin
						st_nxt.earlyPulse = 1'b1;
					end
				end
			end
			pfc_pkg::ST_PRINT: begin
				// Head paced by the step divider
				stepEn        = (st_r.divCnt == STEP_LAST);
				st_nxt.divCnt = stepEn ? 16'h0000 : st_r.divCnt + 16'h0001;
				if (lineEnd) begin
					st_nxt.fsm = pfc_pkg::ST_END;
				end else if (stepEn) begin
					r                = st_r.route[st_r.pos];
					st_nxt.posStrobe = 1'b1;
					st_nxt.posIdx    = st_r.pos;
					if (onNow) begin
						if (r < 7'(`PFC_TRACK_LEN)) begin
							st_nxt.charStrobe = 1'b1;
							st_nxt.charCode   = st_r.track[r];
						end else if (r == `PFC_ROUTE_SPACE) begin
							st_nxt.spaceStrobe = 1'b1;
						end else begin
							// Unrouted position in print-on state aborts the line
							st_nxt.setupErr = 1'b1;
							st_nxt.checkInd = 1'b1;
							st_nxt.fsm      = pfc_pkg::ST_END;
						end
					end
					st_nxt.pos = st_r.pos + 7'h01;
					if (st_r.pos == `PFC_LAST_POS) begin
						st_nxt.fsm = pfc_pkg::ST_END;
					end
				end
				st_nxt.printOn = onNow;
			end
			pfc_pkg::ST_END: begin
				st_nxt.lineDone = 1'b1;
				st_nxt.printOn  = 1'b0;
				st_nxt.fsm      = pfc_pkg::ST_IDLE;
			end
			default: begin
				st_nxt.fsm = pfc_pkg::ST_IDLE;
			end
		endcase
	end

	// Single state register; reset loads constants only
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r           <= '0;
			st_r.fsm       <= pfc_pkg::ST_IDLE;
			st_r.route     <= {`PFC_NUM_POS{`PFC_ROUTE_NONE}};
			st_r.trigRoute <= {`PFC_NUM_ANA{`PFC_ROUTE_NONE}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign prdata      = st_r.prdata;
	assign pready      = st_r.pready;
	assign pslverr     = st_r.pslverr;
	assign busy        = (st_r.fsm != pfc_pkg::ST_IDLE);
	assign posStrobe   = st_r.posStrobe;
	assign posIdx      = st_r.posIdx;
	assign charStrobe  = st_r.charStrobe;
	assign charCode    = st_r.charCode;
	assign spaceStrobe = st_r.spaceStrobe;
	assign lineDone    = st_r.lineDone;
	assign setupErr    = st_r.setupErr;
	assign checkInd    = st_r.checkInd;
	assign earlyPulse  = st_r.earlyPulse;
	assign latePulse   = st_r.latePulse;
	assign resDigit0   = st_r.resDigit[0];
	assign resDigit1   = st_r.resDigit[1];
	assign resZone0    = st_r.resZone[0];
	assign resZone1    = st_r.resZone[1];
	assign resBlank0   = st_r.resBlank[0];
	assign resBlank1   = st_r.resBlank[1];

endmodule : pfc_format_control

// *** dv/pfc_format_control_properties.sv ***
// Purpose: Port-level checks of the printer format control block.
// Assumes: One clock, active-low async reset, pulses one cycle wide.
// Notes: Bound into every instance of the design.
`timescale 1ns/1ns
`include "pfc_map.svh"
module pfc_format_control_properties #(
	parameter int STEP_DIV = 4
) (
	input wire logic                    ref_clk,
	input wire logic                    reset_n,
	input wire logic                    lineEnd,
	input wire logic                    parityErr,
	input wire logic                    checkReset,
	input wire logic                    busy,
	input wire logic                    posStrobe,
	input wire logic [`PFC_ROUTE_W-1:0] posIdx,
	input wire logic                    charStrobe,
	input wire logic                    spaceStrobe,
	input wire logic                    lineDone,
	input wire logic                    setupErr,
	input wire logic                    checkInd,
	input wire logic                    earlyPulse,
	input wire logic                    latePulse,
	input wire logic [9:0]              resDigit0,
	input wire logic [9:0]              resDigit1,
	input wire logic [2:0]              resZone0,
	input wire logic                    resBlank0
);
	logic [15:0]             gap_r;
	logic [`PFC_ROUTE_W-1:0] lastIdx_r;
	logic                    seen_r;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Gap and index since the last strobe; forgotten when idle so a line's first strobe is free
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_r     <= 16'h0001;
			lastIdx_r <= '0;
			seen_r    <= 1'b0;
		end else begin
			gap_r  <= posStrobe ? 16'h0001 : gap_r + 16'h0001;
			seen_r <= busy && (seen_r || posStrobe);
			if (posStrobe) begin
				lastIdx_r <= posIdx;
			end
		end
	end

	// Analysis steps before the head leaves home
	sequence analysisRun;
		!earlyPulse [*2] ##1 earlyPulse ##1 !latePulse ##1 latePulse;
	endsequence
	sequence stepThenEnd;
		posStrobe ##1 (lineEnd && busy);
	endsequence

	analysis_order_a: assert property ($rose(busy) |-> analysisRun)
		else $error("analysis pulses out of order");
	quiet_results_a: assert property (!earlyPulse && !latePulse |->
		resDigit0 == 10'h000 && resDigit1 == 10'h000 && resZone0 == 3'h0 && !resBlank0)
		else $error("result lines active outside pulses");
	digit_onehot_a: assert property (earlyPulse || latePulse |->
		$onehot0(resDigit0) && $onehot0(resDigit1) && !(resBlank0 && resDigit0 != 10'h000))
		else $error("digit lines not one-hot");
	step_spacing_a: assert property (posStrobe && seen_r |-> gap_r == STEP_DIV && posIdx == lastIdx_r + 1'b1)
		else $error("position step spacing wrong");
	strobe_pairing_a: assert property (charStrobe || spaceStrobe |->
		posStrobe && !(charStrobe && spaceStrobe) && posIdx <= `PFC_LAST_POS)
		else $error("print or space without position");
	setup_error_a: assert property ($rose(setupErr) |-> checkInd && (posStrobe || $past(posStrobe)))
		else $error("setup error off a position step");
	error_sticky_a: assert property (setupErr && !checkReset |=> setupErr)
		else $error("setup error dropped");
	error_blocks_a: assert property (setupErr |-> !charStrobe && !$rose(busy))
		else $error("printing while setup error");
	parity_check_a: assert property (parityErr |=> checkInd)
		else $error("parity error not shown");
	line_end_a: assert property (stepThenEnd |-> ##[0:3] lineDone)
		else $error("line end ignored");
	line_close_a: assert property (lineDone |=> !busy)
		else $error("busy after line done");
endmodule : pfc_format_control_properties

bind pfc_format_control pfc_format_control_properties #(.STEP_DIV(STEP_DIV)) pfc_format_control_properties_i (
	.ref_clk(ref_clk), .reset_n(reset_n), .lineEnd(lineEnd), .parityErr(parityErr), .checkReset(checkReset),
	.busy(busy), .posStrobe(posStrobe), .posIdx(posIdx), .charStrobe(charStrobe), .spaceStrobe(spaceStrobe),
	.lineDone(lineDone), .setupErr(setupErr), .checkInd(checkInd), .earlyPulse(earlyPulse),
	.latePulse(latePulse), .resDigit0(resDigit0), .resDigit1(resDigit1), .resZone0(resZone0),
	.resBlank0(resBlank0)
);

// *** dv/pfc_panel_model.sv ***
// Purpose: Panel-side model giving print start, print stop and line-end pulses.
// Assumes: Position strobe one cycle wide, posIdx standing with it.
// Notes: Match value 7'h7f never fires.
`timescale 1ns/1ns
module pfc_panel_model (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       posStrobe,
	input  wire logic [6:0] posIdx,
	input  wire logic [6:0] startAt,
	input  wire logic [6:0] stopAt,
	input  wire logic [6:0] endAt,
	output logic            printStart,
	output logic            printStop,
	output logic            lineEnd
);
	// One cycle after the strobe, so a pulse lands before the next step
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			printStart <= 1'b0;
			printStop  <= 1'b0;
			lineEnd    <= 1'b0;
		end else begin
			printStart <= posStrobe && posIdx == startAt;
			printStop  <= posStrobe && posIdx == stopAt;
			lineEnd    <= posStrobe && posIdx == endAt;
		end
	end
endmodule : pfc_panel_model

// *** dv/printer_format_control_tb_top.sv ***
// Purpose: Self-checking bench of the printer format control block.
// Assumes: STEP_DIV 4, APB with one access cycle, panel model drives control pulses.
// Notes: Analyzer cases from a table; walk, line end and errors by hand.
`timescale 1ns/1ns
`include "pfc_map.svh"
module printer_format_control_tb_top;
	typedef struct {
		logic [5:0]  code;
		logic [13:0] res;
	} pfc_row_t;
	localparam logic [13:0] BLANK = 14'h0001;
	// Code beside its digit, zone and blank lines
	pfc_row_t rows [6] = '{
		'{6'h06, {10'h040, 3'h0, 1'b0}},
		'{6'h11, {10'h002, 3'h1, 1'b0}},
		'{6'h0a, {10'h001, 3'h0, 1'b0}},
		'{6'h00, BLANK},
		'{6'h39, {10'h200, 3'h4, 1'b0}},
		'{6'h29, {10'h200, 3'h2, 1'b0}}
	};
	logic        ref_clk       = 1'b0;
	logic        reset_n       = 1'b0;
	logic        psel          = 1'b0;
	logic        penable       = 1'b0;
	logic        pwrite        = 1'b0;
	logic [11:0] paddr         = 12'h000;
	logic [31:0] pwdata        = 32'h0;
	logic        parityErr     = 1'b0;
	logic        checkReset    = 1'b0;
	logic [1:0]  multiLineStep = 2'h0;
	logic [6:0]  startAt       = 7'h7f;
	logic [6:0]  stopAt        = 7'h7f;
	logic [6:0]  endAt         = 7'h7f;
	logic        pready, pslverr, printStart, printStop, lineEnd, busy, posStrobe, charStrobe, spaceStrobe;
	logic        lineDone, setupErr, checkInd, earlyPulse, latePulse, resBlank0, resBlank1, err;
	logic [31:0] prdata, q;
	logic [6:0]  posIdx;
	logic [5:0]  charCode;
	logic [9:0]  resDigit0, resDigit1;
	logic [2:0]  resZone0, resZone1;
	logic [5:0]  charAt [80];
	logic [79:0] spcAt;
	logic [27:0] earlyRes, lateRes;
	int          nStrobe, n_mismatch, samples_checked;

	always #5 ref_clk = ~ref_clk;

	pfc_format_control #(.STEP_DIV(4)) pfc_format_control_i (
		.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .printStart(printStart),
		.printStop(printStop), .lineEnd(lineEnd), .parityErr(parityErr), .checkReset(checkReset),
		.multiLineStep(multiLineStep), .busy(busy), .posStrobe(posStrobe), .posIdx(posIdx),
		.charStrobe(charStrobe), .charCode(charCode), .spaceStrobe(spaceStrobe), .lineDone(lineDone),
		.setupErr(setupErr), .checkInd(checkInd), .earlyPulse(earlyPulse), .latePulse(latePulse),
		.resDigit0(resDigit0), .resDigit1(resDigit1), .resZone0(resZone0), .resZone1(resZone1),
		.resBlank0(resBlank0), .resBlank1(resBlank1));
	pfc_panel_model pfc_panel_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .posStrobe(posStrobe),
		.posIdx(posIdx), .startAt(startAt), .stopAt(stopAt), .endAt(endAt), .printStart(printStart),
		.printStop(printStop), .lineEnd(lineEnd));

	// Record what each line printed; pulses stand one cycle so one edge sees each
	always @(posedge ref_clk) begin
		if (posStrobe === 1'b1) nStrobe <= nStrobe + 1;
		if (charStrobe === 1'b1) charAt[posIdx] <= charCode;
		if (spaceStrobe === 1'b1) spcAt[posIdx] <= 1'b1;
		if (earlyPulse === 1'b1) earlyRes <= {resDigit0, resZone0, resBlank0, resDigit1, resZone1, resBlank1};
		if (latePulse === 1'b1) lateRes <= {resDigit0, resZone0, resBlank0, resDigit1, resZone1, resBlank1};
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Request held until pready is sampled high; then an idle edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic re);
		int n;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rq = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			tally_and_finish();
		end
		@(posedge ref_clk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic        re;
		apb(1'b1, a, d, rq, re);
		chk("write response", {31'h0, re}, 32'h0);
	endtask : wr

	// One print command, then a bounded wait for the line to finish
	task automatic runLine();
		int n;
		nStrobe = 0;
		spcAt = '0;
		earlyRes = '0;
		lateRes = '0;
		foreach (charAt[i]) charAt[i] = 6'h3f;
		wr(`PFC_OFS_CMD, 32'h1);
		for (n = 0; lineDone !== 1'b1 && n < 2000; n++) @(posedge ref_clk);
		if (n >= 2000) begin
			n_mismatch++;
			tally_and_finish();
		end
		repeat (2) @(posedge ref_clk);
	endtask : runLine

	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, `PFC_OFS_STATUS, 32'h0, q, err);
		chk("status", q, 32'h0);
		apb(1'b0, `PFC_ROUTE_BASE, 32'h0, q, err);
		chk("route reset", q, 32'h7f);
		apb(1'b0, 12'h100, 32'h0, q, err);
		chk("unmapped", {err, q[30:0]}, 32'h80000000);
		wr(`PFC_OFS_CMD, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("open interlock", {31'h0, busy}, 32'h0);
		wr(`PFC_OFS_CTRL, 32'h1);
		for (int k = 0; k < 4; k++) begin
			wr(`PFC_ANA_BASE + 12'(4 * k), 32'(k));
		end
		foreach (rows[i]) begin
			wr(`PFC_TRACK_BASE, 32'(rows[i].code));
			wr(`PFC_TRACK_BASE + 12'h00c, 32'(rows[i].code));
			runLine();
			chk("early", 32'(earlyRes), 32'({rows[i].res, BLANK}));
			chk("late", 32'(lateRes), 32'({BLANK, rows[i].res}));
			chk("strobes", 32'(nStrobe), 32'd80);
			chk("print off", {31'h0, setupErr}, 32'h0);
		end
		$display("test analyzer table done");
		wr(`PFC_ANA_BASE + 12'h00c, 32'h7f);
		runLine();
		chk("open trigger", 32'(lateRes[13:0]), 32'(BLANK));
		multiLineStep <= 2'h1;
		runLine();
		chk("open trigger multi", 32'(lateRes[13:0]), 32'h0);
		multiLineStep <= 2'h0;
		$display("test open trigger done");
		wr(`PFC_OFS_CTRL, 32'h3);
		wr(`PFC_TRACK_BASE + 12'h014, 32'h05);
		wr(`PFC_TRACK_BASE + 12'h01c, 32'h11);
		for (int i = 0; i < 80; i++) begin
			wr(`PFC_ROUTE_BASE + 12'(4 * i), (i == 0) ? 32'd5 : (i == 2) ? 32'd7 : 32'h64);
		end
		runLine();
		chk("char pos0", 32'(charAt[0]), 32'h05);
		chk("char pos2", 32'(charAt[2]), 32'h11);
		chk("char pos1", 32'(charAt[1]), 32'h3f);
		chk("spaces", spcAt[31:0], 32'hfffffffa);
		chk("clean walk", {31'h0, setupErr}, 32'h0);
		endAt <= 7'd9;
		runLine();
		chk("line end", 32'(nStrobe), 32'd10);
		endAt <= 7'h7f;
		$display("test walk done");
		wr(`PFC_ROUTE_BASE + 12'h014, 32'h7f);
		wr(`PFC_ROUTE_BASE + 12'h020, 32'h7f);
		stopAt <= 7'd3;
		startAt <= 7'd6;
		runLine();
		chk("error strobes", 32'(nStrobe), 32'd9);
		chk("errors", {30'h0, setupErr, checkInd}, 32'h3);
		wr(`PFC_OFS_CMD, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("blocked", {31'h0, busy}, 32'h0);
		checkReset <= 1'b1;
		@(posedge ref_clk);
		checkReset <= 1'b0;
		parityErr <= 1'b1;
		@(posedge ref_clk);
		parityErr <= 1'b0;
		repeat (2) @(posedge ref_clk);
		apb(1'b0, `PFC_OFS_STATUS, 32'h0, q, err);
		chk("after clear", {29'h0, q[3:1]}, 32'h2);
		$display("test errors done");
		tally_and_finish();
	end
endmodule : printer_format_control_tb_top
